// >>> rtl/dcr_pkg.sv
/*
 * Package for the digitizer channel configuration register bank.
 * Holds register offsets, field positions, reset values and timing counts.
 * Assumes a 25 MHz system clock and a classic Wishbone slave with 32-bit data.
 */
package dcr_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned HOLDOFF_US       = 10;
  localparam int unsigned HOLDOFF_CYC      = (HOLDOFF_US * (CLK_HZ / 1_000_000) > 0) ?
                                             HOLDOFF_US * (CLK_HZ / 1_000_000) : 1;
  localparam logic [8:0]  HOLDOFF_CNT      = 9'(HOLDOFF_CYC);

  // ****************************************
  // Register offsets (printed offsets are not multiples of four, so index * 4)
  // ****************************************
  localparam logic [7:0] IDX_SAMPLES_HI    = 8'h18;
  localparam logic [7:0] IDX_SAMPLES_LO    = 8'h1a;
  localparam logic [7:0] IDX_FLASH_ADDR    = 8'h1c;
  localparam logic [7:0] IDX_FLASH_DATA    = 8'h1e;
  localparam logic [7:0] IDX_CAL_SRC       = 8'h20;
  localparam logic [7:0] IDX_CACHE_CNT     = 8'h22;
  localparam logic [7:0] IDX_PAIR_A        = 8'h24;
  localparam logic [7:0] IDX_PAIR_B        = 8'h26;
  localparam logic [7:0] IDX_THRESH1       = 8'h28;
  localparam logic [7:0] IDX_LIMIT_STAT    = 8'h40;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam logic [4:0]  FLASH_KEY        = 5'h0a;
  localparam int unsigned KEY_LSB          = 11;
  localparam int unsigned CAL_RANGE_BIT    = 15;
  localparam int unsigned CAL_SEL_LSB      = 12;
  localparam int unsigned CHAN_SHORT_BIT   = 3;
  localparam int unsigned CHAN_ROUTE_BIT   = 7;
  localparam logic [2:0]  GAIN_TOP         = 3'h6;
  localparam logic [2:0]  FILT_BYPASS      = 3'h7;
  localparam logic [15:0] RST_VAL          = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       route;
    logic [2:0] filter;
    logic       ground_tie;
    logic [2:0] gain;
  } dcr_chan_s;

  typedef struct packed {
    logic        range_narrow;
    logic [1:0]  cal_output_select;
    logic [11:0] dac;
  } dcr_cal_s;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  data;
  } dcr_flash_s;

endpackage

// >>> rtl/dcr_regs.sv
/*
 * Digitizer channel configuration register bank, Wishbone classic slave.
 * Assumes the acquisition core supplies the samples count and first-channel
 * 8-bit corrected samples with a one-cycle valid, all on clk_i.
 */
// Our own choice: the Wishbone interface to the registers.
// Functional notes
// RQ1: Low 16 bits of samples count readable, live.
// RQ2: High 16 bits of samples count readable, live.
// RQ3: Flash address holds 11 bits; bits 15-11 read zero.
// RQ4: Flash write needs key 01010 in bits 15-11, else aborted.
// RQ5: Flash data holds one byte; upper byte reads zero.
// RQ6: Cal source takes 12-bit DAC value and range bit 15.
// RQ7: Bits 13-12 select cal output: source, raw DAC, reference, short.
// RQ8: Cache count taken from low byte; upper byte written zero.
// RQ9: One byte per channel; first channel high byte; reads back.
// RQ10: Bus held off 10 us after each channel register write.
// RQ11: Gain codes 000-110; 111 acts as 110.
// RQ12: Short bit ties inputs to short, else connect bit routes.
// RQ13: Filter code selects cutoff; 111 bypasses filter.
// RQ14: Connect bit 0 front panel, 1 calibration bus.
// RQ15: Second pair register controls channels three and four alike.
// RQ16: Host prefers one 32-bit access for both pair registers; here each pair register is its own word, low 16 bits only.
// RQ17: Threshold is 8-bit signed in 15-8; bits 7-1 read zero.
// RQ18: Bit 0 selects sense: 0 above, 1 below.
// RQ19: Limit flag raised when latest sample crosses threshold.
// RQ20: Compare once per new sample with current register contents.
`timescale 1ns/1ps
module dcr_regs
  import dcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [31:0] samples_taken_i,
  input  wire logic [7:0]  ch1_sample_i,
  input  wire logic        ch1_sample_vld_i,
  output dcr_chan_s [3:0]  chan_cfg_o,
  output logic      [3:0]  input_ground_tie_o,
  output logic      [3:0]  input_route_o,
  output logic             chan_load_o,
  output dcr_cal_s         cal_src_o,
  output dcr_flash_s       flash_o,
  output logic             flash_addr_wr_o,
  output logic             flash_data_wr_o,
  output logic      [7:0]  cache_count_o,
  output logic             limit_flag_first_o
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic        req;
  logic        wr;
  logic [7:0]  idx;
  logic [15:0] wdata;
  logic [8:0]  hold_r;
  logic [15:0] rd_nxt;
  logic [15:0] pair_a_r;
  logic [15:0] pair_b_r;
  logic [15:0] thresh_r;
  logic        chan_wr;

  // Word index from byte address; data sits in the low half
  assign idx     = adr_i[9:2];
  assign wdata   = dat_i[15:0];
  assign req     = cyc_i && stb_i && !ack_o;
  assign wr      = req && we_i && (hold_r == 9'h000) && (sel_i[1:0] == 2'b11);
  assign chan_wr = wr && ((idx == IDX_PAIR_A) || (idx == IDX_PAIR_B));

  // Gain code folding, 111 behaves as 110
  function automatic logic [2:0] fold_gain(input logic [2:0] g);
    fold_gain = (g > GAIN_TOP) ? GAIN_TOP : g;
  endfunction

  // Flash key check in bits 15-11
  function automatic logic key_ok(input logic [15:0] w);
    key_ok = (w[15:KEY_LSB] == FLASH_KEY);
  endfunction

  // ****************************************
  // Hold-off and acknowledge
  // ****************************************
  // RQ10: hold-off counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_r <= 9'h000;
    end else if (chan_wr) begin
      hold_r <= HOLDOFF_CNT;
    end else if (hold_r != 9'h000) begin
      hold_r <= hold_r - 9'h001;
    end
  end

  // RQ10: ack withheld while held off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req && (hold_r == 9'h000);
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // RQ9: channel bytes stored as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_a_r <= RST_VAL;
      pair_b_r <= RST_VAL;
    end else if (chan_wr) begin
      if (idx == IDX_PAIR_A) begin
        pair_a_r <= wdata;
      end else begin
        // RQ15: second pair same layout
        pair_b_r <= wdata;
      end
    end
  end

  // Transfer strobe to isolated channel circuitry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_load_o <= 1'b0;
    end else begin
      chan_load_o <= chan_wr;
    end
  end

  // Per-channel outputs, first channel in high byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_cfg_o         <= '0;
      input_ground_tie_o <= 4'h0;
      input_route_o      <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        logic [7:0] b;
        b = (i < 2) ? pair_a_r[(1 - i) * 8 +: 8] : pair_b_r[(3 - i) * 8 +: 8];
        // RQ11: gain folded
        chan_cfg_o[i].gain       <= fold_gain(b[2:0]);
        // RQ13: filter code passed, 111 bypass
        chan_cfg_o[i].filter     <= b[6:4];
        chan_cfg_o[i].ground_tie <= b[CHAN_SHORT_BIT];
        chan_cfg_o[i].route      <= b[CHAN_ROUTE_BIT];
        // RQ12: short overrides routing
        input_ground_tie_o[i]    <= b[CHAN_SHORT_BIT];
        // RQ14: route 0 panel, 1 cal bus
        input_route_o[i]         <= b[CHAN_ROUTE_BIT] && !b[CHAN_SHORT_BIT];
      end
    end
  end

  // RQ6: cal source register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_src_o <= '0;
    end else if (wr && (idx == IDX_CAL_SRC)) begin
      cal_src_o.dac               <= wdata[11:0];
      cal_src_o.range_narrow      <= wdata[CAL_RANGE_BIT];
      // RQ7: output select bits 13-12
      cal_src_o.cal_output_select <= wdata[CAL_SEL_LSB +: 2];
    end
  end

  // RQ8: cache count from low byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cache_count_o <= 8'h00;
    end else if (wr && (idx == IDX_CACHE_CNT)) begin
      cache_count_o <= wdata[7:0];
    end
  end

  // RQ4: flash writes taken only with key
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_o         <= '0;
      flash_addr_wr_o <= 1'b0;
      flash_data_wr_o <= 1'b0;
    end else begin
      flash_addr_wr_o <= wr && (idx == IDX_FLASH_ADDR) && key_ok(wdata);
      flash_data_wr_o <= wr && (idx == IDX_FLASH_DATA) && key_ok(wdata);
      if (wr && (idx == IDX_FLASH_ADDR) && key_ok(wdata)) begin
        // RQ3: 11-bit address
        flash_o.addr <= wdata[10:0];
      end
      if (wr && (idx == IDX_FLASH_DATA) && key_ok(wdata)) begin
        // RQ5: one data byte
        flash_o.data <= wdata[7:0];
      end
    end
  end

  // RQ17: threshold and sense bit stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thresh_r <= RST_VAL;
    end else if (wr && (idx == IDX_THRESH1)) begin
      thresh_r <= {wdata[15:8], 7'h00, wdata[0]};
    end
  end

  // ****************************************
  // Limit compare
  // ****************************************
  // RQ20: once per sample, current threshold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_flag_first_o <= 1'b0;
    end else if (ch1_sample_vld_i) begin
      // RQ18: sense bit selects direction
      // RQ19: flag on crossing
      if (thresh_r[0]) begin
        limit_flag_first_o <= $signed(ch1_sample_i) < $signed(thresh_r[15:8]);
      end else begin
        limit_flag_first_o <= $signed(ch1_sample_i) > $signed(thresh_r[15:8]);
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Read mux; write-only and unmapped read zero
  always_comb begin
    rd_nxt = 16'h0000;
    unique case (idx)
      // RQ2: high count word
      IDX_SAMPLES_HI: rd_nxt = samples_taken_i[31:16];
      // RQ1: low count word
      IDX_SAMPLES_LO: rd_nxt = samples_taken_i[15:0];
      IDX_FLASH_ADDR: rd_nxt = {5'h00, flash_o.addr};
      IDX_FLASH_DATA: rd_nxt = {8'h00, flash_o.data};
      IDX_PAIR_A:     rd_nxt = pair_a_r;
      IDX_PAIR_B:     rd_nxt = pair_b_r;
      IDX_THRESH1:    rd_nxt = thresh_r;
      IDX_LIMIT_STAT: rd_nxt = {15'h0000, limit_flag_first_o};
      default:        rd_nxt = 16'h0000;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= {16'h0000, rd_nxt};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  hold_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    chan_wr |=> ack_o ##1 !ack_o [*8])
    else $error("ack during channel hold-off");

  hold_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    chan_wr |=> hold_r == HOLDOFF_CNT)
    else $error("hold-off count wrong");

  key_abort_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    (wr && idx == IDX_FLASH_ADDR && !key_ok(wdata)) |=> !flash_addr_wr_o && $stable(flash_o.addr))
    else $error("flash write without key");

  gain_fold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
    chan_cfg_o[0].gain != 3'h7)
    else $error("gain code 111 not folded");

  route_tie_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
    !(input_route_o[1] && input_ground_tie_o[1]))
    else $error("route active while shorted");

  thr_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    thresh_r[7:1] == 7'h00)
    else $error("threshold reserved bits set");

  sense_above_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ18
    (ch1_sample_vld_i && !thresh_r[0] && $signed(ch1_sample_i) > $signed(thresh_r[15:8]))
    |=> limit_flag_first_o)
    else $error("above-limit sample not flagged");

  sense_below_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
    (ch1_sample_vld_i && thresh_r[0] && $signed(ch1_sample_i) >= $signed(thresh_r[15:8]))
    |=> !limit_flag_first_o)
    else $error("below sense flagged wrongly");

  cal_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
    (wr && idx == IDX_CAL_SRC) |=> cal_src_o.cal_output_select == $past(wdata[13:12]))
    else $error("cal output select not taken");

  cache_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    (wr && idx == IDX_CACHE_CNT) |=> cache_count_o == $past(wdata[7:0]))
    else $error("cache count not taken");

  hold_stall_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    (hold_r != 9'h000) |=> !ack_o)
    else $error("ack given while held off");

  hold_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    (hold_r != 9'h000) |=> hold_r == $past(hold_r) - 9'h001)
    else $error("hold-off count not stepping down");

  load_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    chan_wr |=> chan_load_o ##1 !chan_load_o)
    else $error("channel load strobe missing");

  key_data_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    (wr && idx == IDX_FLASH_DATA && !key_ok(wdata))
    |=> !flash_data_wr_o && $stable(flash_o.data))
    else $error("flash data write without key");

  key_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    (flash_addr_wr_o || flash_data_wr_o) |-> $past(wr && key_ok(wdata)))
    else $error("flash strobe without key");

  addr_hi_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    (req && !we_i && idx == IDX_FLASH_ADDR) |=> dat_o[15:11] == 5'h00)
    else $error("flash address upper bits not zero");

  data_hi_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
    (req && !we_i && idx == IDX_FLASH_DATA) |=> dat_o[15:8] == 8'h00)
    else $error("flash data upper byte not zero");

  gain_all_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
    chan_cfg_o[1].gain != 3'h7 && chan_cfg_o[2].gain != 3'h7 && chan_cfg_o[3].gain != 3'h7)
    else $error("gain code 111 not folded");

  route_all_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
    (input_route_o & input_ground_tie_o) == 4'h0)
    else $error("a shorted channel is routed");

  route_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
    !input_ground_tie_o[0] |-> input_route_o[0] == chan_cfg_o[0].route)
    else $error("route does not follow connect bit");

  sense_lt_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ18
    (ch1_sample_vld_i && thresh_r[0] && $signed(ch1_sample_i) < $signed(thresh_r[15:8]))
    |=> limit_flag_first_o)
    else $error("below-limit sample not flagged");

  sense_le_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
    (ch1_sample_vld_i && !thresh_r[0] && $signed(ch1_sample_i) <= $signed(thresh_r[15:8]))
    |=> !limit_flag_first_o)
    else $error("above sense flagged wrongly");

  flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
    !ch1_sample_vld_i |=> $stable(limit_flag_first_o))
    else $error("limit flag moved without a sample");

  thr_sense_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ18
    (wr && idx == IDX_THRESH1) |=> thresh_r[0] == $past(wdata[0]))
    else $error("compare sense bit not taken");

  thr_data_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    (wr && idx == IDX_THRESH1) |=> thresh_r[15:8] == $past(wdata[15:8]))
    else $error("threshold limit not taken");

  cal_dac_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
    (wr && idx == IDX_CAL_SRC) |=> cal_src_o.dac == $past(wdata[11:0]))
    else $error("cal DAC value not taken");

  count_lo_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    (req && !we_i && idx == IDX_SAMPLES_LO) |=> dat_o[15:0] == $past(samples_taken_i[15:0]))
    else $error("low count word wrong");

  count_hi_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    (req && !we_i && idx == IDX_SAMPLES_HI) |=> dat_o[15:0] == $past(samples_taken_i[31:16]))
    else $error("high count word wrong");

endmodule

// >>> test/dcr_host.sv
/*
 * Host model: classic Wishbone master issuing single 32-bit cycles.
 * Assumes a slave that answers with a one-cycle ack, possibly after a hold-off.
 */
`timescale 1ns/1ps
module dcr_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [9:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  output logic             hang_o
);
  // ***************
  // Bus cycle
  // ***************
  // Idle bus at time zero
  initial begin
    cyc_o  = 1'b0;
    stb_o  = 1'b0;
    we_o   = 1'b0;
    adr_o  = 10'h000;
    sel_o  = 4'h0;
    dat_o  = 32'h0000_0000;
    hang_o = 1'b0;
  end

  task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
                      output logic [31:0] q, output int n);
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 400);
    q = dat_i;
    if (ack_i !== 1'b1) hang_o <= 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// >>> test/digitizer_channel_config_regs_tb_top.sv
/*
 * Testbench for the channel configuration register bank.
 * Assumes dcr_host as bus master and a 25 MHz clock.
 */
`timescale 1ns/1ps
module digitizer_channel_config_regs_tb_top;
  import dcr_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, vld, hang, flag, load, faw, fdw;
  logic [9:0] adr;
  logic [3:0] sel, tie, route;
  logic [31:0] wdat, rdat, cnt;
  logic [7:0] smp, cache;
  dcr_chan_s [3:0] cfg;
  dcr_cal_s cal;
  dcr_flash_s fl;
  int bad_count, n_tests;
  int n_load, n_faw, n_fdw;

  dcr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .samples_taken_i(cnt), .ch1_sample_i(smp), .ch1_sample_vld_i(vld),
    .chan_cfg_o(cfg), .input_ground_tie_o(tie), .input_route_o(route),
    .chan_load_o(load), .cal_src_o(cal), .flash_o(fl), .flash_addr_wr_o(faw),
    .flash_data_wr_o(fdw), .cache_count_o(cache), .limit_flag_first_o(flag));
  dcr_host host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hang_o(hang));

  // ***************
  // Helpers
  // ***************
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    logic [31:0] q;
    int n;
    host_u.xfer(1'b1, {i, 2'b00}, d, q, n);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] q, output int n);
    host_u.xfer(1'b0, {i, 2'b00}, 16'h0000, q, n);
  endtask
  task automatic samp(input logic [7:0] v);
    @(posedge clk_i);
    smp <= v;
    vld <= 1'b1;
    @(posedge clk_i);
    vld <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ***************
  // Scenarios
  // ***************
  task automatic t_count();
    logic [31:0] q;
    int n;
    cnt <= 32'h1234_5678;
    rd(IDX_SAMPLES_LO, q, n);
    chk("count_lo", 32'h0000_5678, q);
    cnt <= 32'h1234_9abc;
    rd(IDX_SAMPLES_LO, q, n);
    chk("count_live", 32'h0000_9abc, q);
    rd(IDX_SAMPLES_HI, q, n);
    chk("count_hi", 32'h0000_1234, q);
    rd(8'hff, q, n);
    chk("unmapped", 32'h0000_0000, q);
    rd(IDX_PAIR_A, q, n);
    chk("pair_rst", {16'h0000, RST_VAL}, q);
    $display("count done");
  endtask
  task automatic t_flash();
    logic [31:0] q;
    int n;
    wr(IDX_FLASH_ADDR, 16'h57ff);
    rd(IDX_FLASH_ADDR, q, n);
    chk("faddr", 32'h0000_07ff, q);
    chk("faddr_stb", 1, n_faw);
    wr(IDX_FLASH_ADDR, 16'h0123);
    rd(IDX_FLASH_ADDR, q, n);
    chk("faddr_nokey", 32'h0000_07ff, q);
    chk("faddr_nostb", 1, n_faw);
    wr(IDX_FLASH_DATA, 16'h55a5);
    rd(IDX_FLASH_DATA, q, n);
    chk("fdata", 32'h0000_00a5, q);
    wr(IDX_FLASH_DATA, 16'h0011);
    rd(IDX_FLASH_DATA, q, n);
    chk("fdata_nokey", 32'h0000_00a5, q);
    chk("fdata_stb", 1, n_fdw);
    chk("flash_o", {13'h0000, 11'h7ff, 8'ha5}, fl);
    $display("flash done");
  endtask
  task automatic t_cal_cache();
    logic [31:0] q;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CAL_SRC, {1'(s), 1'b0, 2'(s), 12'h5a3});
      chk("cal", {1'(s), 2'(s), 12'h5a3}, cal);
    end
    wr(IDX_CACHE_CNT, 16'h007e);
    chk("cache", 32'h0000_007e, cache);
    rd(IDX_CAL_SRC, q, n);
    chk("cal_wo", 32'h0000_0000, q);
    $display("cal done");
  endtask
  task automatic t_chan();
    logic [31:0] q;
    int n;
    wr(IDX_PAIR_A, 16'hf73a);
    rd(IDX_PAIR_A, q, n);
    chk("holdoff", 1, n >= 240 && n <= 260);
    chk("pair_a", 32'h0000_f73a, q);
    chk("load_a", 1, n_load);
    chk("ch1", 8'hf6, cfg[0]);
    chk("ch2", 8'h3a, cfg[1]);
    wr(IDX_PAIR_B, 16'h9d83);
    rd(IDX_PAIR_B, q, n);
    chk("pair_b", 32'h0000_9d83, q);
    chk("ch3", 8'h9d, cfg[2]);
    chk("ch4", 8'h83, cfg[3]);
    chk("load_b", 2, n_load);
    chk("tie", 4'b0110, tie);
    chk("route", 4'b1001, route);
    $display("chan done");
  endtask
  task automatic t_limit();
    logic [31:0] q;
    int n;
    wr(IDX_THRESH1, 16'h10fe);
    rd(IDX_THRESH1, q, n);
    chk("thresh", 32'h0000_1000, q);
    samp(8'h20);
    chk("above", 1, flag);
    samp(8'h10);
    chk("equal", 0, flag);
    wr(IDX_THRESH1, 16'h1001);
    samp(8'hf0);
    chk("below", 1, flag);
    rd(IDX_LIMIT_STAT, q, n);
    chk("flag_rd", 1, q);
    samp(8'h7f);
    chk("not_below", 0, flag);
    $display("limit done");
  endtask

  // ***************
  // Run
  // ***************
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Strobe pulse counters
  always @(posedge clk_i) begin
    if (load === 1'b1) n_load <= n_load + 1;
    if (faw === 1'b1) n_faw <= n_faw + 1;
    if (fdw === 1'b1) n_fdw <= n_fdw + 1;
  end
  // Hung bus cycle
  always @(posedge hang) begin
    $display("[ERR] bus_ack expected 1 seen 0");
    bad_count++;
    conclude();
  end
  // Main sequence
  initial begin
    rst_i = 1'b1;
    cnt = 32'h0000_0000;
    smp = 8'h00;
    vld = 1'b0;
    bad_count = 0;
    n_tests = 0;
    n_load = 0;
    n_faw = 0;
    n_fdw = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_count();
    t_flash();
    t_cal_cache();
    t_chan();
    t_limit();
    conclude();
  end
endmodule
